// ---- hw/ipx_pkg.sv ----
/*
 Shared constants and types of the interrupt priority and external
 trigger controller: register offsets, masks, reset values, encodings.
 Assumes a 32-bit AXI4-Lite bus with byte addresses on 8 bits.
*/
package ipx_pkg;

   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFS_PRIO0   = 8'h00; // four priority registers
   localparam logic [7:0] OFS_TRIG0   = 8'h10; // four trigger registers
   localparam logic [7:0] OFS_EN_LO   = 8'h20;
   localparam logic [7:0] OFS_EN_HI   = 8'h24;
   localparam logic [7:0] OFS_FLAG_LO = 8'h28;
   localparam logic [7:0] OFS_FLAG_HI = 8'h2c;
   localparam logic [7:0] OFS_PINSEL  = 8'h30;
   localparam logic [7:0] OFS_CTRL    = 8'h34; // global enable
   localparam logic [7:0] OFS_STATUS  = 8'h38; // read-only service state
   localparam logic [7:0] OFS_STEP    = 8'h04;

   // Reset value and writable masks
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [7:0] EN_LO_MASK  = 8'hfc;
   localparam logic [7:0] PINSEL_MASK = 8'h03;
   localparam logic [7:0] CTRL_MASK   = 8'h01;

   // Source numbers in polling order of the two private vectors
   localparam logic [3:0] SRC_EXT0 = 4'h0;
   localparam logic [3:0] SRC_EXT1 = 4'h2;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Priority codes
   localparam logic [1:0] LVL_LOWEST  = 2'h0;
   localparam logic [1:0] LVL_HIGHEST = 2'h3;

   // Trigger type of one external input
   typedef enum logic [1:0] {
      TRIG_LOW  = 2'h0,
      TRIG_FALL = 2'h1,
      TRIG_RISE = 2'h2,
      TRIG_BOTH = 2'h3
   } ipx_trig_t;

   // Request offered to the CPU core
   typedef struct packed {
      logic       valid;
      logic [3:0] id;
      logic [1:0] level;
   } ipx_irq_t;

   // Events from the CPU core
   typedef struct packed {
      logic ack;  // current request taken
      logic reti; // service routine ended
   } ipx_cpu_evt_t;

endpackage

// ---- hw/ipx_ctrl.sv ----
/*
 Interrupt priority and external trigger controller: priority fields,
 trigger selection and request flags of sixteen external inputs,
 enables of inputs 2-15, pin choice for inputs 0 and 1, and the priority arbiter.
 Assumes an AXI4-Lite master on aclk, raw asynchronous pins, and a CPU
 core that pulses ack and reti on aclk.
*/
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
// How it works
// - Two-bit level, 00 lowest, 11 highest
// - Level register 0: t1, ext1, t0, ext0
// - Level register 1: serial b, lvd, wdt, serial a
// - Level register 2: pwm, t4, t3, spi
// - Level register 3: ext groups, adc, t5
// - Two-bit trigger per input, four per register
// - Disabled inputs 2-15 never set flags
// - Low enable bits 1-0 read zero, unwritable
// - High enable bits enable inputs 15-8
// - Flags 2-7 cleared only by software zero
// - Flags 0-1 also cleared on acceptance
// - Flags 8-15 cleared only by software zero
// - Pin choice bit 1 selects ext1 port
// - Pin choice bit 0 selects ext0 port
// - Only strictly higher level preempts service
// - Equal levels resolved by polling order
// - Nothing delivered without global enable
`timescale 1ns/1ns
module ipx_ctrl (
   // Clock and reset
   input  logic                       aclk,
   input  logic                       aresetn,
   // AXI4-Lite write address and data
   input  logic [ipx_pkg::ADDR_W-1:0] awaddr,
   input  logic                       awvalid,
   output logic                       awready,
   input  logic [ipx_pkg::DATA_W-1:0] wdata,
   input  logic [3:0]                 wstrb,
   input  logic                       wvalid,
   output logic                       wready,
   // AXI4-Lite write response
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  logic                       bready,
   // AXI4-Lite read
   input  logic [ipx_pkg::ADDR_W-1:0] araddr,
   input  logic                       arvalid,
   output logic                       arready,
   output logic [ipx_pkg::DATA_W-1:0] rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  logic                       rready,
   // External pins
   input  logic [1:0]                 port0_pins,
   input  logic [1:0]                 port1_pins,
   input  logic [15:2]                ext_pins,
   // Peripheral sources and CPU core
   input  logic [15:0]                periph_pend,
   input  logic [15:0]                src_enable,
   input  ipx_pkg::ipx_cpu_evt_t      cpu_evt,
   output ipx_pkg::ipx_irq_t          irq
);

   // Bus state
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0]  aw_addr_reg;   // held write address
   logic [7:0]  w_data_reg;    // held write byte
   logic        w_strb_reg;    // held lane 0 strobe

   // Software registers
   logic [3:0][7:0] prio_reg;  // four level registers
   logic [3:0][7:0] trig_reg;  // four trigger registers
   logic [7:0]      en_lo_reg;
   logic [7:0]      en_hi_reg;
   logic [15:0]     flags_reg;
   logic [15:0]     flags_next;
   logic [7:0]      pinsel_reg;
   logic            ge_reg;    // global_irq_enable

   // Pin sampling
   logic [17:0] sync1_reg;     // first stage, read by sync2 only
   logic [17:0] sync2_reg;
   logic [15:0] cur;           // selected, synchronised inputs
   logic [15:0] prev_reg;      // previous sample of cur

   // Arbitration
   logic [3:0]  in_svc_reg;    // one bit per level in service
   logic [3:0]  in_svc_next;
   ipx_pkg::ipx_irq_t irq_reg;
   ipx_pkg::ipx_irq_t irq_next;

   // Valid, aligned, mapped address
   function automatic logic addr_ok(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= ipx_pkg::OFS_STATUS);
   endfunction

   // Trigger detector for one input
   function automatic logic trig_hit(input logic [1:0] t,
                                     input logic p, input logic c);
      logic hit;
      hit = 1'b0;
      unique case (ipx_pkg::ipx_trig_t'(t))
         ipx_pkg::TRIG_LOW:  hit = !c;
         ipx_pkg::TRIG_FALL: hit = p && !c;
         ipx_pkg::TRIG_RISE: hit = !p && c;
         ipx_pkg::TRIG_BOTH: hit = p ^ c;
      endcase
      return hit;
   endfunction

   // Winner: highest level, lowest index on ties
   function automatic logic [6:0] pick(input logic [15:0] req,
                                       input logic [31:0] lv);
      logic       found;
      logic [3:0] id;
      logic [1:0] best;
      found = 1'b0;
      id    = 4'h0;
      best  = ipx_pkg::LVL_LOWEST;
      for (int i = 0; i < 16; i++) begin
         // Strict compare keeps the earlier source on a tie
         if (req[i] && (!found || lv[2*i+:2] > best)) begin
            found = 1'b1;
            id    = 4'(i);
            best  = lv[2*i+:2];
         end
      end
      return {found, id, best};
   endfunction

   // Outputs straight from flops
   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;
   assign irq     = irq_reg;

   // Write fires once both address and data are held
   wire       wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
   wire       wr_en   = wr_fire && addr_ok(aw_addr_reg) && w_strb_reg;
   wire [7:0] wa      = aw_addr_reg;
   wire       wr_enlo = wr_en && wa == ipx_pkg::OFS_EN_LO;
   wire       wr_enhi = wr_en && wa == ipx_pkg::OFS_EN_HI;
   wire       wr_fl   = wr_en && wa == ipx_pkg::OFS_FLAG_LO;
   wire       wr_fh   = wr_en && wa == ipx_pkg::OFS_FLAG_HI;
   wire       wr_pin  = wr_en && wa == ipx_pkg::OFS_PINSEL;
   wire       wr_ctl  = wr_en && wa == ipx_pkg::OFS_CTRL;

   // Handshakes
   wire aw_hs = awvalid && awready_reg;
   wire w_hs  = wvalid && wready_reg;
   wire b_hs  = bvalid_reg && bready;
   wire ar_hs = arvalid && arready_reg;
   wire r_hs  = rvalid_reg && rready;

   // Write channel: each side held until response taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= ipx_pkg::RESP_OKAY;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 8'h00;
         w_strb_reg  <= 1'b0;
      end else begin
         // Address taken
         if (aw_hs) begin
            awready_reg <= 1'b0;
            aw_addr_reg <= awaddr;
         end
         // Data taken; only lane 0 carries a register
         if (w_hs) begin
            wready_reg <= 1'b0;
            w_data_reg <= wdata[7:0];
            w_strb_reg <= wstrb[0];
         end
         // Answer one cycle after both are held
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= addr_ok(aw_addr_reg) ? ipx_pkg::RESP_OKAY
                                               : ipx_pkg::RESP_SLVERR;
         end else if (b_hs) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // Read byte selection
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      unique case (araddr)
         ipx_pkg::OFS_PRIO0:                    rd_byte = prio_reg[0];
         ipx_pkg::OFS_PRIO0 + ipx_pkg::OFS_STEP: rd_byte = prio_reg[1];
         ipx_pkg::OFS_PRIO0 + 8'h08:            rd_byte = prio_reg[2];
         ipx_pkg::OFS_PRIO0 + 8'h0c:            rd_byte = prio_reg[3];
         ipx_pkg::OFS_TRIG0:                    rd_byte = trig_reg[0];
         ipx_pkg::OFS_TRIG0 + ipx_pkg::OFS_STEP: rd_byte = trig_reg[1];
         ipx_pkg::OFS_TRIG0 + 8'h08:            rd_byte = trig_reg[2];
         ipx_pkg::OFS_TRIG0 + 8'h0c:            rd_byte = trig_reg[3];
         ipx_pkg::OFS_EN_LO:   rd_byte = en_lo_reg;
         ipx_pkg::OFS_EN_HI:   rd_byte = en_hi_reg;
         ipx_pkg::OFS_FLAG_LO: rd_byte = flags_reg[7:0];
         ipx_pkg::OFS_FLAG_HI: rd_byte = flags_reg[15:8];
         ipx_pkg::OFS_PINSEL:  rd_byte = pinsel_reg;
         ipx_pkg::OFS_CTRL:    rd_byte = {7'h00, ge_reg};
         ipx_pkg::OFS_STATUS:  rd_byte = {3'h0, irq_reg.valid, in_svc_reg};
         default:              rd_byte = 8'h00;
      endcase
   end

   // Read channel: data captured with the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= ipx_pkg::RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end else if (ar_hs) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= {24'h00_0000, rd_byte};
         rresp_reg   <= addr_ok(araddr) ? ipx_pkg::RESP_OKAY
                                        : ipx_pkg::RESP_SLVERR;
      end else if (r_hs) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // Level and trigger registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prio_reg <= {4{ipx_pkg::RST_BYTE}};
         trig_reg <= {4{ipx_pkg::RST_BYTE}};
      end else begin
         for (int k = 0; k < 4; k++) begin
            // Field layout is fixed by source order
            if (wr_en && wa == ipx_pkg::OFS_PRIO0 + 8'(4 * k))
               prio_reg[k] <= w_data_reg;
            // Four inputs per register from bit 0
            if (wr_en && wa == ipx_pkg::OFS_TRIG0 + 8'(4 * k))
               trig_reg[k] <= w_data_reg;
         end
      end
   end

   // Enables, pin choice and global enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_lo_reg  <= ipx_pkg::RST_BYTE;
         en_hi_reg  <= ipx_pkg::RST_BYTE;
         pinsel_reg <= ipx_pkg::RST_BYTE;
         ge_reg     <= 1'b0;
      end else begin
         // Low two bits stay zero
         if (wr_enlo)
            en_lo_reg <= w_data_reg & ipx_pkg::EN_LO_MASK;
         if (wr_enhi)
            en_hi_reg <= w_data_reg;
         // Upper six bits stay zero
         if (wr_pin)
            pinsel_reg <= w_data_reg & ipx_pkg::PINSEL_MASK;
         if (wr_ctl)
            ge_reg <= |(w_data_reg & ipx_pkg::CTRL_MASK);
      end
   end

   // Pin synchronisers
   // Cleared to the idle high level: a zero here would fake a low level
   // and a rising edge on every quiet pin just after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 18'h3_ffff;
         sync2_reg <= 18'h3_ffff;
         prev_reg  <= 16'hffff;
      end else begin
         sync1_reg <= {ext_pins, port1_pins, port0_pins};
         sync2_reg <= sync1_reg;
         prev_reg  <= cur;
      end
   end

   // Port choice for inputs 0 and 1; a change may fake one edge
   assign cur[0]    = pinsel_reg[0] ? sync2_reg[2] : sync2_reg[0];
   assign cur[1]    = pinsel_reg[1] ? sync2_reg[3] : sync2_reg[1];
   assign cur[15:2] = sync2_reg[17:4];

   // Per-input trigger events
   wire [31:0] trig_flat = trig_reg;
   wire [15:0] ev;
   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_trig
         assign ev[g] = trig_hit(trig_flat[2*g+:2], prev_reg[g], cur[g]);
      end
   endgenerate

   // Inputs 0 and 1 have no individual enable
   wire [15:0] en_vec = {en_hi_reg, en_lo_reg[7:2], 2'h3};
   // Disabled inputs do not set
   wire [15:0] set_vec = ev & en_vec;

   // Acceptance clears only the private vectors
   wire        took   = cpu_evt.ack && irq_reg.valid;
   wire [15:0] hw_clr = {14'h0000,
                         took && irq_reg.id == ipx_pkg::SRC_EXT1,
                         took && irq_reg.id == ipx_pkg::SRC_EXT0};
   // Writing zero clears, writing one keeps
   wire [15:0] sw_clr = {wr_fh ? ~w_data_reg : 8'h00,
                         wr_fl ? ~w_data_reg : 8'h00};

   // Set wins over any clear in the same cycle
   assign flags_next = (flags_reg & ~hw_clr & ~sw_clr) | set_vec;

   // Request flags
   always_ff @(posedge aclk) begin
      if (!aresetn)
         flags_reg <= 16'h0000;
      else
         flags_reg <= flags_next;
   end

   // Pending vector in polling order; groups OR their flags
   wire [15:0] pend = {|flags_reg[15:8], |flags_reg[7:2], periph_pend[13:3],
                       flags_reg[1], periph_pend[1], flags_reg[0]};
   wire [15:0] req  = pend & src_enable;

   // Level now in service, highest bit set
   wire       any_act = |in_svc_reg;
   wire [1:0] act_lvl = in_svc_reg[3] ? 2'h3 : in_svc_reg[2] ? 2'h2 :
                        in_svc_reg[1] ? 2'h1 : 2'h0;

   // Arbiter result
   wire [31:0] lv_flat = prio_reg;
   wire [6:0]  win     = pick(req, lv_flat);
   wire        win_ok  = win[6] && (!any_act || win[1:0] > act_lvl);

   // Next request and service state
   always_comb begin
      // Dropped on the ack cycle so the same request is not taken twice
      irq_next.valid = win_ok && ge_reg && !cpu_evt.ack;
      irq_next.id    = win[5:2];
      irq_next.level = win[1:0];
      in_svc_next    = in_svc_reg;
      // Return ends the innermost service
      if (cpu_evt.reti && any_act)
         in_svc_next[act_lvl] = 1'b0;
      if (took)
         in_svc_next[irq_reg.level] = 1'b1;
   end

   // Request register and service stack
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_reg    <= '0;
         in_svc_reg <= 4'h0;
      end else begin
         irq_reg    <= irq_next;
         in_svc_reg <= in_svc_next;
      end
   end

   // Disabled input never raises its flag
   property p_dis_hold;
      @(posedge aclk) disable iff (!aresetn)
      1 |=> ((flags_reg & ~$past(flags_reg) & ~$past(en_vec)) == 16'h0000);
   endproperty
   a_dis_hold: assert property (p_dis_hold)
      else $error("flag set on disabled input");

   // Reserved enable bits read zero
   property p_enlo_rsv;
      @(posedge aclk) disable iff (!aresetn)
      (ar_hs && araddr == ipx_pkg::OFS_EN_LO) |=> (rdata_reg[1:0] == 2'h0);
   endproperty
   a_enlo_rsv: assert property (p_enlo_rsv)
      else $error("reserved enable bits read nonzero");

   // Group flags survive acceptance without a write
   property p_grp_keep;
      @(posedge aclk) disable iff (!aresetn)
      (took && !wr_fl && !wr_fh) |=>
         ((~flags_reg & $past(flags_reg) & 16'hfffc) == 16'h0000);
   endproperty
   a_grp_keep: assert property (p_grp_keep)
      else $error("group flag lost on acceptance");

   // Ext0 flag cleared when taken
   property p_ext0_clr;
      @(posedge aclk) disable iff (!aresetn)
      (took && irq_reg.id == ipx_pkg::SRC_EXT0 && !ev[0]) |=> !flags_reg[0];
   endproperty
   a_ext0_clr: assert property (p_ext0_clr)
      else $error("ext0 flag not cleared on acceptance");

   // Pin choice upper bits read zero
   property p_pin_rsv;
      @(posedge aclk) disable iff (!aresetn)
      (ar_hs && araddr == ipx_pkg::OFS_PINSEL) |=> (rdata_reg[7:2] == 6'h00);
   endproperty
   a_pin_rsv: assert property (p_pin_rsv)
      else $error("pin choice upper bits nonzero");

   // Offered level exceeds level in service
   property p_preempt;
      @(posedge aclk) disable iff (!aresetn)
      irq_reg.valid |-> (!$past(any_act) || irq_reg.level > $past(act_lvl));
   endproperty
   a_preempt: assert property (p_preempt)
      else $error("request not above level in service");

   // No request without global enable
   property p_global;
      @(posedge aclk) disable iff (!aresetn)
      !ge_reg |=> !irq_reg.valid;
   endproperty
   a_global: assert property (p_global)
      else $error("request with global enable off");

   // Falling edge on input 0 sets its flag next cycle
   property p_fall0;
      @(posedge aclk) disable iff (!aresetn)
      (trig_reg[0][1:0] == 2'h1 && prev_reg[0] && !cur[0]) |=> flags_reg[0];
   endproperty
   a_fall0: assert property (p_fall0)
      else $error("falling edge missed on input 0");

   // Level, trigger, high enable and pin choice registers zero at release of reset
   property p_rst_zero;
      @(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> (prio_reg == '0 && trig_reg == '0 &&
                          en_hi_reg == 8'h00 && pinsel_reg == 8'h00);
   endproperty
   a_rst_zero: assert property (p_rst_zero)
      else $error("register not zero after reset");

   // Main scenarios
   c_take: cover property (@(posedge aclk) disable iff (!aresetn) took);
   c_nest: cover property (@(posedge aclk) disable iff (!aresetn)
                           any_act && irq_reg.valid);
   c_wr:   cover property (@(posedge aclk) disable iff (!aresetn) b_hs);

endmodule

// ---- sim/ipx_cpu_model.sv ----
/*
 CPU core stand-in: accepts offered requests when the bench grants one,
 after a chosen lag, and ends a service on command.
 Assumes the controller's irq and cpu_evt ports on the same clock.
*/
`timescale 1ns/1ns
module ipx_cpu_model (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Controller side
   input  wire ipx_pkg::ipx_irq_t irq,
   output ipx_pkg::ipx_cpu_evt_t  cpu_evt = '0,
   // Bench commands
   input  wire logic              take,
   input  wire logic              ret,
   input  wire logic [2:0]        lag
);
   logic       armed = 1'b0;  // One ack granted by the bench
   logic [2:0] waited = 3'h0; // Cycles spent before answering

   // Ack only while a request is offered, so a slow core still acks
   // a live request and never a stale one
   always @(posedge aclk) begin
      cpu_evt.ack <= 1'b0;
      cpu_evt.reti <= ret & aresetn;
      if (!aresetn) begin
         armed <= 1'b0;
      end else if (take) begin
         armed <= 1'b1;
         waited <= 3'h0;
      end else if (armed && irq.valid) begin
         if (waited == lag) begin
            cpu_evt.ack <= 1'b1;
            armed <= 1'b0;
         end else begin
            waited <= waited + 3'h1;
         end
      end
   end
endmodule

// ---- sim/irq_priority_ext_trigger_ctrl_tb_top.sv ----
/*
 Self-checking bench of the priority and external trigger controller.
 Assumes ipx_ctrl and ipx_cpu_model compiled before it.
*/
`timescale 1ns/1ns
module irq_priority_ext_trigger_ctrl_tb_top;
   // Bus, pins and core wires
   logic                  aclk = 1'b0;
   logic                  aresetn = 1'b0;
   logic [7:0]            awaddr = 8'h00, araddr = 8'h00, d, v;
   logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                  arvalid = 1'b0, rready = 1'b0;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [31:0]           wdata = 32'h0, rdata;
   logic [3:0]            wstrb = 4'h0;
   logic [1:0]            bresp, rresp, rs;
   logic [1:0]            port0_pins = 2'h3, port1_pins = 2'h3;
   logic [15:2]           ext_pins = 14'h3fff;
   logic [15:0]           periph_pend = 16'h0, src_enable = 16'h0;
   ipx_pkg::ipx_cpu_evt_t cpu_evt;
   ipx_pkg::ipx_irq_t     irq;
   logic                  take = 1'b0, ret = 1'b0;
   logic [2:0]            lag = 3'h0;
   int                    n_fail = 0, check_count = 0;

   // 25 MHz clock
   always #20 aclk = ~aclk;

   ipx_ctrl i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .port0_pins, .port1_pins, .ext_pins,
      .periph_pend, .src_enable, .cpu_evt, .irq);
   ipx_cpu_model i_cpu (.aclk, .aresetn, .irq, .cpu_evt, .take, .ret, .lag);

   task automatic stop_test;
      if (n_fail == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, dv, output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h0, dv};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 300);
      r = bresp;
      bready <= 1'b0;
      if (n >= 300) n_fail++;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] dv, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 300);
      dv = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
      if (n >= 300) n_fail++;
      @(posedge aclk);
   endtask

   task automatic w(input logic [7:0] a, dv);
      wr(a, dv, rs);
      chk("bresp", 32'(rs), 32'(ipx_pkg::RESP_OKAY));
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, e);
      rd(a, v, rs);
      chk(nm, {22'h0, rs, v}, {22'h0, ipx_pkg::RESP_OKAY, e});
   endtask

   // Drive masked pins low, or all high, then let the sync settle
   task automatic pins(input int g, input logic [15:0] m, input logic lo);
      if (g == 0) port0_pins <= lo ? ~m[1:0] : 2'h3;
      else if (g == 1) port1_pins <= lo ? ~m[1:0] : 2'h3;
      else ext_pins <= lo ? ~m[15:2] : 14'h3fff;
      tick(6);
   endtask

   // Grant one ack with a random lag, then wait 12 cycles
   task automatic acc;
      lag <= 3'($urandom);
      take <= 1'b1;
      tick(1);
      take <= 1'b0;
      tick(12);
   endtask

   task automatic rt;
      ret <= 1'b1;
      tick(1);
      ret <= 1'b0;
      tick(3);
   endtask

   initial begin
      d = 8'($urandom(45230));
      tick(10);
      aresetn <= 1'b1;
      tick(1);
      for (int i = 0; i < 15; i++) rchk("reset", 8'(4 * i), 8'h00);
      rd(8'h3c, v, rs);
      chk("unmapped read", 32'(rs), 32'(ipx_pkg::RESP_SLVERR));
      wr(8'h3c, 8'hff, rs);
      chk("unmapped write", 32'(rs), 32'(ipx_pkg::RESP_SLVERR));
      // Random read-back; reserved bits stay zero
      for (int i = 0; i < 13; i++) if (i < 10 || i == 12) begin
         d = 8'($urandom);
         w(8'(4 * i), d);
         rchk("rw", 8'(4 * i), d & (i == 8 ? ipx_pkg::EN_LO_MASK :
            i == 12 ? ipx_pkg::PINSEL_MASK : 8'hff));
         w(8'(4 * i), 8'h00);
      end
      // Every trigger code on input 9
      for (int m = 0; m < 4; m++) begin
         w(8'h24, 8'h00);
         w(8'h18, 8'(m << 2));
         pins(2, 16'h0200, 1);
         pins(2, 16'h0, 0);
         rchk("disabled", 8'h2c, 8'h00);
         w(8'h24, 8'h02);
         pins(2, 16'h0200, 1);
         rchk("fall", 8'h2c, m == 2 ? 8'h00 : 8'h02);
         w(8'h2c, 8'h00);
         rchk("low level", 8'h2c, m == 0 ? 8'h02 : 8'h00);
         pins(2, 16'h0, 0);
         rchk("rise", 8'h2c, m == 1 ? 8'h00 : 8'h02);
         w(8'h24, 8'h00);
         w(8'h2c, 8'h00);
         rchk("clear", 8'h2c, 8'h00);
      end
      // Pin choice of inputs 0 and 1, falling edge mode
      w(8'h10, 8'h05);
      for (int s = 0; s < 2; s++) begin
         w(8'h30, s ? 8'h03 : 8'h00);
         w(8'h28, 8'h00);
         pins(s ? 0 : 1, 16'h3, 1);
         pins(s ? 0 : 1, 16'h0, 0);
         rchk("other port", 8'h28, 8'h00);
         pins(s, 16'h3, 1);
         pins(s, 16'h0, 0);
         rchk("chosen port", 8'h28, 8'h03);
      end
      w(8'h30, 8'h00);
      w(8'h28, 8'h00);
      // Arbitration
      src_enable <= 16'hffff;
      periph_pend <= 16'h000a;
      tick(8);
      chk("no global", 32'(irq.valid), 32'h0);
      w(8'h34, 8'h01);
      tick(3);
      chk("tie", 32'(irq), 32'({1'b1, 4'h1, 2'h0}));
      for (int k = 1; k < 14; k++) if (k != 2) begin
         d = 8'(1 + $urandom_range(2));
         periph_pend <= 16'(1 << k);
         w(8'(4 * (k / 4)), 8'(d << (2 * (k % 4))));
         tick(3);
         chk("level", 32'(irq), 32'({1'b1, 4'(k), d[1:0]}));
         w(8'(4 * (k / 4)), 8'h00);
      end
      periph_pend <= 16'h000a;
      w(8'h00, 8'h84);
      acc();
      chk("equal held", 32'(irq.valid), 32'h0);
      w(8'h00, 8'h8c);
      tick(3);
      chk("preempt", 32'(irq), 32'({1'b1, 4'h1, 2'h3}));
      acc();
      rchk("in service", 8'h38, 8'h0c);
      rt();
      chk("after end", 32'(irq), 32'({1'b1, 4'h1, 2'h3}));
      periph_pend <= 16'h0;
      w(8'h00, 8'h00);
      rt();
      // Acceptance clears input 0 flag only
      w(8'h10, 8'h11);
      w(8'h20, 8'h04);
      pins(0, 16'h1, 1);
      pins(0, 16'h0, 0);
      pins(2, 16'h4, 1);
      pins(2, 16'h0, 0);
      chk("ext0 offer", 32'(irq), 32'({1'b1, 4'h0, 2'h0}));
      acc();
      rchk("ext0 taken", 8'h28, 8'h04);
      rt();
      acc();
      rchk("group taken", 8'h28, 8'h04);
      rt();
      stop_test();
   end

   // Hang guard, far above the expected run length
   initial begin
      #2000000;
      n_fail++;
      stop_test();
   end
endmodule
